// [testbench/hbd_master.sv]
// Serial master model facing the motor bridge control block
`timescale 1ns/1ps
module hbd_master (
  // Clock
  input  wire logic        i_clock,
  // Serial pins
  input  wire logic        i_miso,
  input  wire logic        i_miso_oe,
  output logic             o_sclk,
  output logic             o_chip_select_n,
  output logic             o_mosi,
  // Result
  output logic [15:0]      o_rx,
  output logic             o_done
);
  wire line = i_miso_oe ? i_miso : 1'bz;

  initial begin
    o_sclk = 1'b0;
    o_chip_select_n = 1'b1;
    o_mosi = 1'b0;
    o_rx = 16'h0000;
    o_done = 1'b0;
  end

  // One select for this device only
  task frame(input logic [17:0] d, input int n);
    o_rx = 16'h0000;
    o_chip_select_n = 1'b0;
    repeat (6) @(negedge i_clock);
    for (int i = n - 1; i >= 0; i--) begin
      o_sclk = 1'b1;
      o_mosi = d[i];
      repeat (4) @(negedge i_clock);
      o_sclk = 1'b0;
      repeat (4) @(negedge i_clock);
      o_rx = {o_rx[14:0], line};
    end
    o_chip_select_n = 1'b1;
    // Released data line must not look held
    o_mosi = ~o_mosi;
    repeat (8) @(negedge i_clock);
    o_done = 1'b1;
    @(negedge i_clock);
    o_done = 1'b0;
  endtask : frame

  // Line activity while deselected
  task noise(input int n);
    repeat (n) begin
      o_sclk = 1'($urandom);
      o_mosi = 1'($urandom);
      repeat (2) @(negedge i_clock);
    end
    o_sclk = 1'b0;
  endtask : noise
endmodule : hbd_master

// [testbench/testbench.sv]
// Self-checking bench of the motor bridge serial control
`timescale 1ns/1ps
module testbench;
  import hbd_pkg::*;
  typedef struct packed {
    logic [15:0] sts;
    logic [15:0] m;
    logic [5:0]  sw;
    logic [2:0]  flg;
  } hbd_exp_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] det = 3'h0;
  logic [2:0] flg = 3'h0;
  logic [5:0] ctl = 6'h00;
  logic sclk, cs_n, mosi, miso, oe;
  logic [5:0] sw;
  logic [2:0] fo;
  logic [15:0] rx;
  logic done;
  int lens[4] = '{14, 15, 17, 18};
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  hbd_exp_t exp_q[$];

  initial forever #10 clk = ~clk;

  hbd_master hbd_master_i (.i_clock(clk), .i_miso(miso), .i_miso_oe(oe), .o_sclk(sclk),
    .o_chip_select_n(cs_n), .o_mosi(mosi), .o_rx(rx), .o_done(done));
  hbd_spi_ctrl hbd_spi_ctrl_i (.i_clock(clk), .i_sys_rst(rst), .i_sclk(sclk), .i_chip_select_n(cs_n),
    .i_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(oe), .i_supply_overvoltage_det(det[2]),
    .i_overtemp_det(det[1]), .i_overcurrent_det(det[0]), .o_switch_on(sw),
    .o_supply_overvoltage_flag(fo[2]), .o_overtemp_flag(fo[1]), .o_overcurrent_flag(fo[0]));

  function automatic logic [5:0] eff();
    logic [5:0] e;
    e = ctl;
    for (int p = 0; p < 6; p += 2) if (e[p] & e[p+1]) e[p+:2] = 2'b00;
    return (|flg) ? 6'h00 : e;
  endfunction : eff

  task complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run

  task send(input logic [17:0] d, input int n);
    logic [15:0] w;
    hbd_exp_t e;
    w = (n == 15) ? {1'b0, d[14:0]} : d[15:0];
    e.sts = {flg, eff(), 7'h00};
    e.m = (n == 16) ? 16'hffff : 16'h0000;
    if (n >= 15 && n <= 17) begin
      if (w[15] & w[0]) begin
        flg = det;
        ctl = 6'h00;
      end else begin
        flg = (flg & ~w[15:13]) | det;
        ctl = w[12:7];
      end
    end
    e.sw = eff();
    e.flg = flg;
    exp_q.push_back(e);
    hbd_master_i.frame(d, n);
  endtask : send

  task fault(input int k);
    det[k] = 1'b1;
    flg[k] = 1'b1;
    repeat (6) @(negedge clk);
    det[k] = 1'b0;
    repeat (2) @(negedge clk);
  endtask : fault

  always @(posedge done) begin
    hbd_exp_t e;
    checks++;
    if (exp_q.size() == 0) begin
      fails++;
      $display("unexpected at %0t: result with no note", $time);
    end else begin
      e = exp_q.pop_front();
      if (((rx ^ e.sts) & e.m) !== 16'h0000 || sw !== e.sw || fo !== e.flg || oe !== 1'b0) begin
        fails++;
        $display("unexpected at %0t: rx %h sw %h flags %h", $time, rx, sw, fo);
      end
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      complete_run();
    end
  end

  initial begin
    void'($urandom(87));
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    send(18'h00000, 16);
    repeat (6) send(18'($urandom) & 18'h01ffe, 16);
    foreach (lens[i]) send(18'($urandom) & 18'h31ffe, lens[i]);
    send(18'h01f80, 16);
    for (int k = 0; k < 3; k++) begin
      fault(k);
      send(18'h01500, 16);
      send(18'h01500 | (18'h02000 << k), 16);
      send(18'h00600, 16);
    end
    fault(0);
    fault(1);
    fault(2);
    send(18'h01f81, 16);
    send(18'h09f81, 16);
    send(18'h00000, 16);
    hbd_master_i.noise(40);
    send(18'h00a80, 16);
    send(18'h00000, 16);
    repeat (20) @(negedge clk);
    complete_run();
  end
endmodule : testbench

// [verilog/hbd_pkg.sv]
// Package: field layout, frame limits and reset values of the motor bridge serial control
package hbd_pkg;

  // Frame length window, counted in sampled bits
  localparam logic [4:0]  HBD_MIN_BITS     = 5'h0f;
  localparam logic [4:0]  HBD_MAX_BITS     = 5'h11;
  localparam logic [4:0]  HBD_CNT_SAT      = 5'h1f;
  localparam int          HBD_WORD_BITS    = 16;
  localparam int          HBD_NUM_SW       = 6;
  localparam int          HBD_NUM_PAIRS    = 3;
  localparam int          HBD_SYNC_STAGES  = 2;

  // Bit positions in the command and status words
  localparam int          HBD_BIT_OV       = 15;
  localparam int          HBD_BIT_OT       = 14;
  localparam int          HBD_BIT_OC       = 13;
  localparam int          HBD_BIT_SW_HI    = 12;
  localparam int          HBD_BIT_SW_LO    = 7;
  localparam int          HBD_BIT_ARM      = 0;

  // Reset values
  localparam logic [15:0] HBD_RX_RST       = 16'h0000;
  localparam logic [15:0] HBD_TX_RST       = 16'h0000;
  localparam logic [5:0]  HBD_SW_RST       = 6'h00;
  localparam logic        HBD_FLAG_RST     = 1'b0;
  // Synchronised pins rest at idle levels, select high
  localparam logic [5:0]  HBD_PINS_RST     = 6'h10;

  // Command word, bit 15 down to bit 0
  typedef struct packed {
    logic       overvoltage_clear;
    logic       overtemp_clear;
    logic       overcurrent_clear;
    logic [5:0] sw_ctl;            // ctl_c2_low .. ctl_b2_high
    logic [5:0] outer_ctl;         // bridge rows not handled here
    logic       status_clear_arm;
  } hbd_cmd_t;

  // Status word, bit 15 down to bit 0
  typedef struct packed {
    logic       supply_overvoltage_flag;
    logic       overtemp_flag;
    logic       overcurrent_flag;
    logic [5:0] sw_sts;            // sts_c2_low .. sts_b2_high
    logic [6:0] zero;
  } hbd_sts_t;

  // Synchronised pin and detector levels
  typedef struct packed {
    logic sclk;
    logic chip_select_n;
    logic mosi;
    logic det_ov;
    logic det_ot;
    logic det_oc;
  } hbd_pins_t;

endpackage : hbd_pkg

// [verilog/hbd_spi_ctrl.sv]
// Serial command/status interface and fault latches of the half-bridge motor driver
`timescale 1ns/1ps
module hbd_spi_ctrl
  import hbd_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_sys_rst,
  // Serial pins from the master
  input  wire logic       i_sclk,
  input  wire logic       i_chip_select_n,
  input  wire logic       i_mosi,
  // Serial output pin
  output logic            o_spi_miso,
  output logic            o_spi_miso_oe,
  // Analog fault detectors, asynchronous levels
  input  wire logic       i_supply_overvoltage_det,
  input  wire logic       i_overtemp_det,
  input  wire logic       i_overcurrent_det,
  // Switch drives, c2_low at bit 5 down to b2_high at bit 0
  output logic [5:0]      o_switch_on,
  // Sticky fault flags
  output logic            o_supply_overvoltage_flag,
  output logic            o_overtemp_flag,
  output logic            o_overcurrent_flag
);

  hbd_pins_t   pins_s;
  logic        sclk_d_ff;
  logic        csn_d_ff;
  logic [4:0]  bit_cnt_ff;
  logic [4:0]  nxt_bit_cnt;
  logic [15:0] rx_ff;
  logic [15:0] nxt_rx;
  logic [15:0] tx_ff;
  logic [15:0] nxt_tx;
  logic        oe_ff;
  logic [5:0]  ctl_ff;
  logic [5:0]  nxt_ctl;
  logic [5:0]  switch_ff;
  logic [5:0]  nxt_switch;
  logic        ov_ff;
  logic        ot_ff;
  logic        oc_ff;
  logic        nxt_ov;
  logic        nxt_ot;
  logic        nxt_oc;

  // Pins and detectors cross into the core clock
  // Idle reset levels avoid a false select edge after reset
  hbd_sync #(
    .WIDTH   ($bits(hbd_pins_t)),
    .RST_VAL (HBD_PINS_RST)
  ) u_sync (
    .i_clock (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_async ({i_sclk, i_chip_select_n, i_mosi,
               i_supply_overvoltage_det, i_overtemp_det, i_overcurrent_det}),
    .o_sync  (pins_s)
  );

  // Edge detection on the synchronised serial clock and select
  wire cs_active  = ~pins_s.chip_select_n;
  wire cs_fall    = ~pins_s.chip_select_n & csn_d_ff;
  wire cs_rise    = pins_s.chip_select_n & ~csn_d_ff;
  wire sclk_fall  = cs_active & ~pins_s.sclk & sclk_d_ff;
  wire sclk_rise  = cs_active & pins_s.sclk & ~sclk_d_ff;

  // Frame qualification and decoded command
  wire        frame_ok  = (bit_cnt_ff >= HBD_MIN_BITS) && (bit_cnt_ff <= HBD_MAX_BITS);
  wire        commit    = cs_rise & frame_ok;
  hbd_cmd_t   cmd;
  assign cmd = hbd_cmd_t'(rx_ff);
  wire        full_clr  = commit & cmd.status_clear_arm & cmd.overvoltage_clear;
  wire        ov_clr    = commit & cmd.overvoltage_clear;
  wire        ot_clr    = commit & (cmd.overtemp_clear | full_clr);
  wire        oc_clr    = commit & (cmd.overcurrent_clear | full_clr);

  // Status word presented to the master
  hbd_sts_t   sts;
  assign sts.supply_overvoltage_flag = ov_ff;
  assign sts.overtemp_flag           = ot_ff;
  assign sts.overcurrent_flag        = oc_ff;
  assign sts.sw_sts                  = switch_ff;
  assign sts.zero                    = '0;

  // Bit counter saturates so long frames stay rejected
  assign nxt_bit_cnt = cs_fall ? 5'h00 :
                       (sclk_fall && bit_cnt_ff != HBD_CNT_SAT) ? bit_cnt_ff + 5'h01 :
                       bit_cnt_ff;
  // Fresh frame starts from zero so a short word has bit 15 low
  wire [15:0] rx_base = cs_fall ? HBD_RX_RST : rx_ff;
  assign nxt_rx      = sclk_fall ? {rx_base[14:0], pins_s.mosi} : rx_base;
  // First bit stands from select fall; shift only after a bit was sampled
  assign nxt_tx      = cs_fall ? 16'(sts) :
                       (sclk_rise && bit_cnt_ff != 5'h00) ? {tx_ff[14:0], 1'b0} :
                       tx_ff;

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sclk_d_ff  <= 1'b0;
      csn_d_ff   <= 1'b1;
      bit_cnt_ff <= 5'h00;
      rx_ff      <= HBD_RX_RST;
      tx_ff      <= HBD_TX_RST;
      oe_ff      <= 1'b0;
    end else begin
      sclk_d_ff  <= pins_s.sclk;
      csn_d_ff   <= pins_s.chip_select_n;
      bit_cnt_ff <= nxt_bit_cnt;
      rx_ff      <= nxt_rx;
      tx_ff      <= nxt_tx;
      oe_ff      <= cs_active;
    end
  end

  // Sticky flags: a detector hit in the clear cycle wins
  assign nxt_ov = pins_s.det_ov | (ov_ff & ~ov_clr);
  assign nxt_ot = pins_s.det_ot | (ot_ff & ~ot_clr);
  assign nxt_oc = pins_s.det_oc | (oc_ff & ~oc_clr);

  // Combined reset drops the controls, so outputs stay off until rewritten
  assign nxt_ctl = full_clr ? HBD_SW_RST :
                   commit   ? cmd.sw_ctl :
                   ctl_ff;

  // Both sides of one half-bridge on forces that leg off
  logic [5:0] shoot_mask;
  for (genvar p = 0; p < HBD_NUM_PAIRS; p++) begin : g_pair
    wire both_on = nxt_ctl[2*p] & nxt_ctl[2*p+1];
    assign shoot_mask[2*p]   = both_on;
    assign shoot_mask[2*p+1] = both_on;
  end

  // Any live fault forces every output off until its flag is cleared
  wire fault_any = nxt_ov | nxt_ot | nxt_oc;
  assign nxt_switch = fault_any ? HBD_SW_RST : (nxt_ctl & ~shoot_mask);

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ov_ff     <= HBD_FLAG_RST;
      ot_ff     <= HBD_FLAG_RST;
      oc_ff     <= HBD_FLAG_RST;
      ctl_ff    <= HBD_SW_RST;
      switch_ff <= HBD_SW_RST;
    end else begin
      ov_ff     <= nxt_ov;
      ot_ff     <= nxt_ot;
      oc_ff     <= nxt_oc;
      ctl_ff    <= nxt_ctl;
      switch_ff <= nxt_switch;
    end
  end

  assign o_spi_miso                = tx_ff[HBD_WORD_BITS-1];
  assign o_spi_miso_oe             = oe_ff;
  assign o_switch_on               = switch_ff;
  assign o_supply_overvoltage_flag = ov_ff;
  assign o_overtemp_flag           = ot_ff;
  assign o_overcurrent_flag        = oc_ff;

  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  sequence s_good_commit;
    cs_rise && frame_ok;
  endsequence

  sequence s_bad_frame;
    cs_rise && !frame_ok;
  endsequence

  property p_ov_set;
    pins_s.det_ov |=> o_supply_overvoltage_flag;
  endproperty
  a_ov_set: assert property (p_ov_set) else $error("over-voltage flag not set");

  property p_ov_sticky;
    o_supply_overvoltage_flag && !ov_clr |=> o_supply_overvoltage_flag;
  endproperty
  a_ov_sticky: assert property (p_ov_sticky) else $error("over-voltage flag dropped");

  property p_ot_sticky;
    o_overtemp_flag && !ot_clr |=> o_overtemp_flag;
  endproperty
  a_ot_sticky: assert property (p_ot_sticky) else $error("over-temperature flag dropped");

  property p_oc_sticky;
    o_overcurrent_flag && !oc_clr |=> o_overcurrent_flag;
  endproperty
  a_oc_sticky: assert property (p_oc_sticky) else $error("over-current flag dropped");

  property p_ov_clear;
    s_good_commit ##0 (cmd.overvoltage_clear && !pins_s.det_ov) |=> !o_supply_overvoltage_flag;
  endproperty
  a_ov_clear: assert property (p_ov_clear) else $error("over-voltage clear ignored");

  property p_ot_clear;
    s_good_commit ##0 (cmd.overtemp_clear && !pins_s.det_ot) |=> !o_overtemp_flag;
  endproperty
  a_ot_clear: assert property (p_ot_clear) else $error("over-temperature clear ignored");

  property p_oc_clear;
    s_good_commit ##0 (cmd.overcurrent_clear && !pins_s.det_oc) |=> !o_overcurrent_flag;
  endproperty
  a_oc_clear: assert property (p_oc_clear) else $error("over-current clear ignored");

  property p_full_reset;
    s_good_commit ##0 (cmd.status_clear_arm && cmd.overvoltage_clear
                       && !pins_s.det_ov && !pins_s.det_ot && !pins_s.det_oc)
      |=> (o_switch_on == 6'h00) && !o_overtemp_flag && !o_overcurrent_flag;
  endproperty
  a_full_reset: assert property (p_full_reset) else $error("status reset incomplete");

  property p_commit;
    s_good_commit ##0 !cmd.status_clear_arm |=> ctl_ff == $past(cmd.sw_ctl);
  endproperty
  a_commit: assert property (p_commit) else $error("command not applied");

  property p_status_mirror;
    ##1 cs_fall |=> tx_ff[12:7] == $past(switch_ff);
  endproperty
  a_status_mirror: assert property (p_status_mirror) else $error("status bits wrong");

  property p_discard;
    s_bad_frame |=> $stable(ctl_ff) && !($fell(o_overcurrent_flag) || $fell(o_overtemp_flag));
  endproperty
  a_discard: assert property (p_discard) else $error("bad frame applied");

  property p_shift_in;
    sclk_fall |=> rx_ff[0] == $past(pins_s.mosi);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("serial input not sampled");

  property p_hiz;
    pins_s.chip_select_n ##1 pins_s.chip_select_n |-> !o_spi_miso_oe;
  endproperty
  a_hiz: assert property (p_hiz) else $error("output driven while idle");

  property p_forced_off;
    (o_supply_overvoltage_flag || o_overtemp_flag || o_overcurrent_flag) |-> o_switch_on == 6'h00;
  endproperty
  a_forced_off: assert property (p_forced_off) else $error("output on during fault");

  property p_ot_set;
    pins_s.det_ot |=> o_overtemp_flag;
  endproperty
  a_ot_set: assert property (p_ot_set) else $error("over-temperature flag not set");

  property p_oc_set;
    pins_s.det_oc |=> o_overcurrent_flag;
  endproperty
  a_oc_set: assert property (p_oc_set) else $error("over-current flag not set");

  property p_no_shoot;
    (o_switch_on & (o_switch_on >> 1) & 6'h15) == 6'h00;
  endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("both sides of a leg on");

  property p_miso_load;
    cs_fall |=> (o_spi_miso == $past(ov_ff)) && o_spi_miso_oe;
  endproperty
  a_miso_load: assert property (p_miso_load) else $error("first status bit missing");

  property p_oe_on;
    cs_active |=> o_spi_miso_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("output not driven while selected");

  property p_miso_hold;
    !sclk_rise && !cs_fall |=> $stable(o_spi_miso);
  endproperty
  a_miso_hold: assert property (p_miso_hold) else $error("serial output moved off a rising edge");

  property p_bit_count;
    sclk_fall && !cs_fall && (bit_cnt_ff != HBD_CNT_SAT) |=> bit_cnt_ff == $past(bit_cnt_ff) + 5'h01;
  endproperty
  a_bit_count: assert property (p_bit_count) else $error("bit not counted");

  property p_idle_ignore;
    pins_s.chip_select_n |=> $stable(rx_ff) && $stable(bit_cnt_ff);
  endproperty
  a_idle_ignore: assert property (p_idle_ignore) else $error("input taken while deselected");

  property p_arm_alone;
    s_good_commit ##0 (cmd.status_clear_arm && !cmd.overvoltage_clear && o_supply_overvoltage_flag)
      |=> o_supply_overvoltage_flag;
  endproperty
  a_arm_alone: assert property (p_arm_alone) else $error("arm bit alone cleared status");

  property p_rx_clear;
    cs_fall |=> rx_ff[15:1] == 15'h0000;
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("stale bits kept at frame start");

endmodule : hbd_spi_ctrl

// [verilog/hbd_sync.sv]
// Two-stage level synchroniser, one lane per bit
`timescale 1ns/1ps
module hbd_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_sys_rst,
  // Levels
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // First stage feeds only the second stage
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule : hbd_sync
